// ### src/angle_gain_offset_correction.sv
// Contract
// - Two-bit gain selector: none, X, Y, Z
// - Gain is unsigned eleven bits over 1024
// - Offset selector zero applies no offset
// - Selector 01b routes first offset by pair
// - Selector 10b routes second offset by pair
// - Selector 11b routes both offsets by pair
// - Offsets are 7-bit signed, 11-bit scale
// - Angle result: 13 bits, sixteenths of degree
// - Magnitude result read-only, resets to zero
`timescale 1ns/1ps
`include "angle_corr_regs.svh"

module angle_gain_offset_correction
    import angle_corr_pkg::*;
(
    // Clock and reset
    input  wire logic               clk_i,
    input  wire logic               nrst_i,
    // Register port
    input  wire logic [5:0]         reg_addr_i,
    input  wire logic               reg_wr_i,
    input  wire logic [15:0]        reg_wdata_i,
    input  wire logic               reg_rd_i,
    output logic [15:0]             reg_rdata_o,
    // Axis data from the conversion logic
    input  wire logic               raw_valid_i,
    input  wire logic signed [15:0] x_raw_i,
    input  wire logic signed [15:0] y_raw_i,
    input  wire logic signed [15:0] z_raw_i,
    input  wire logic [1:0]         angle_pair_i,
    // Results
    output logic                    result_valid_o,
    output logic [15:0]             angle_o,
    output logic [15:0]             magnitude_o
);

    ////////////////////////////////////////////////////////////////////////////////
    // Register file

    logic [15:0] amp_setup_reg, amp_setup_next;
    logic [15:0] ofs_setup_reg, ofs_setup_next;
    logic [15:0] angle_reg, angle_next;
    logic [15:0] vlen_reg, vlen_next;
    logic [15:0] rdata_reg, rdata_next;
    logic        valid_reg, valid_next;

    logic        eng_busy;
    logic        eng_done;
    logic [15:0] eng_angle;
    logic [15:0] eng_mag;

    always_comb begin
        amp_setup_next = amp_setup_reg;
        ofs_setup_next = ofs_setup_reg;
        rdata_next     = rdata_reg;
        if (reg_wr_i) begin
            case (reg_addr_i)
                `AMP_SETUP_OFS: amp_setup_next = {reg_wdata_i[`AMP_SEL_HI:`AMP_SEL_LO], 3'b000,
                                                  reg_wdata_i[`AMP_VAL_HI:`AMP_VAL_LO]};
                `OFS_SETUP_OFS: ofs_setup_next = reg_wdata_i;
                default:        ;
            endcase
        end
        if (reg_rd_i) begin
            case (reg_addr_i)
                `AMP_SETUP_OFS: rdata_next = amp_setup_reg;
                `OFS_SETUP_OFS: rdata_next = ofs_setup_reg;
                `ANGLE_OUT_OFS: rdata_next = angle_reg;
                `VLEN_OUT_OFS:  rdata_next = vlen_reg;
                default:        rdata_next = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            amp_setup_reg <= `AMP_SETUP_RST;
            ofs_setup_reg <= `OFS_SETUP_RST;
            rdata_reg     <= 16'h0000;
        end else begin
            amp_setup_reg <= amp_setup_next;
            ofs_setup_reg <= ofs_setup_next;
            rdata_reg     <= rdata_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Axis correction

    logic [1:0]         gain_sel;
    logic [11:0]        gain_val;
    logic [1:0]         ofs_sel;
    logic signed [17:0] ofs_first;
    logic signed [17:0] ofs_second;
    logic [1:0]         first_axis;
    logic [1:0]         second_axis;
    logic signed [15:0] raw [3];
    logic signed [15:0] corr [3];

    assign gain_sel   = amp_setup_reg[`AMP_SEL_HI:`AMP_SEL_LO];
    assign gain_val   = {1'b0, amp_setup_reg[`AMP_VAL_HI:`AMP_VAL_LO]};
    assign ofs_sel    = ofs_setup_reg[`OFS_SEL_HI:`OFS_SEL_LO];
    assign ofs_first  = 18'(signed'(ofs_setup_reg[`OFS_FIRST_HI:`OFS_FIRST_LO]))
                        <<< `OFS_SHIFT;
    assign ofs_second = 18'(signed'(ofs_setup_reg[`OFS_SECOND_HI:`OFS_SECOND_LO]))
                        <<< `OFS_SHIFT;
    assign raw[0]     = x_raw_i;
    assign raw[1]     = y_raw_i;
    assign raw[2]     = z_raw_i;

    // Axis codes: 1 = X, 2 = Y, 3 = Z, 0 = none
    always_comb begin
        first_axis  = 2'd0;
        second_axis = 2'd0;
        case (axis_pair_t'(angle_pair_i))
            PAIR_XY: begin
                first_axis  = 2'd1;
                second_axis = 2'd2;
            end
            PAIR_YZ: begin
                first_axis  = 2'd2;
                second_axis = 2'd3;
            end
            PAIR_XZ: begin
                first_axis  = 2'd1;
                second_axis = 2'd3;
            end
            default: ;
        endcase
    end

    genvar k;
    generate
        for (k = 0; k < 3; k++) begin : g_axis
            logic signed [27:0] prod;
            logic signed [17:0] scaled;
            logic signed [17:0] sum;
            assign prod   = raw[k] * signed'(gain_val);
            assign scaled = (gain_sel == 2'(k + 1)) ? 18'(prod >>> `GAIN_FRAC_BITS)
                                                    : 18'(raw[k]);
            // Selector bit 0 enables first value, bit 1 the second; both for 11b
            assign sum    = scaled
                          + ((ofs_sel[0] && first_axis == 2'(k + 1)) ? ofs_first : 18'sd0)
                          + ((ofs_sel[1] && second_axis == 2'(k + 1)) ? ofs_second : 18'sd0);
            assign corr[k] = (sum > 18'sd32767)  ? 16'sh7FFF :
                             (sum < -18'sd32768) ? 16'sh8000 : sum[15:0];
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////
    // Operand capture and angle engine

    logic signed [15:0] a_reg, a_next;
    logic signed [15:0] b_reg, b_next;
    logic               start_reg, start_next;

    always_comb begin
        a_next     = a_reg;
        b_next     = b_reg;
        start_next = 1'b0;
        // Samples arriving while the engine runs are dropped
        if (raw_valid_i && angle_pair_i != PAIR_NONE && !eng_busy && !start_reg) begin
            a_next     = (first_axis == 2'd1) ? corr[0] : corr[1];
            b_next     = (second_axis == 2'd2) ? corr[1] : corr[2];
            start_next = 1'b1;
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            a_reg     <= 16'h0000;
            b_reg     <= 16'h0000;
            start_reg <= 1'b0;
        end else begin
            a_reg     <= a_next;
            b_reg     <= b_next;
            start_reg <= start_next;
        end
    end

    rotation_angle_engine u_engine (
        .clk_i   (clk_i),
        .nrst_i  (nrst_i),
        .start_i (start_reg),
        .a_i     (a_reg),
        .b_i     (b_reg),
        .busy_o  (eng_busy),
        .done_o  (eng_done),
        .angle_o (eng_angle),
        .mag_o   (eng_mag)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Result registers

    always_comb begin
        angle_next = angle_reg;
        vlen_next  = vlen_reg;
        valid_next = 1'b0;
        if (eng_done) begin
            angle_next = eng_angle;
            vlen_next  = eng_mag;
            valid_next = 1'b1;
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            angle_reg <= `RESULT_RST;
            vlen_reg  <= `RESULT_RST;
            valid_reg <= 1'b0;
        end else begin
            angle_reg <= angle_next;
            vlen_reg  <= vlen_next;
            valid_reg <= valid_next;
        end
    end

    assign reg_rdata_o    = rdata_reg;
    assign result_valid_o = valid_reg;
    assign angle_o        = angle_reg;
    assign magnitude_o    = vlen_reg;

endmodule

// ### src/angle_corr_regs.svh
`ifndef ANGLE_CORR_REGS_SVH
`define ANGLE_CORR_REGS_SVH

// Register offsets
`define AMP_SETUP_OFS        6'h11
`define OFS_SETUP_OFS        6'h12
`define ANGLE_OUT_OFS        6'h13
`define VLEN_OUT_OFS         6'h14

// Reset values
`define AMP_SETUP_RST        16'h0000
`define OFS_SETUP_RST        16'h0000
`define RESULT_RST           16'h0000

// Field positions
`define AMP_SEL_HI           15
`define AMP_SEL_LO           14
`define AMP_VAL_HI           10
`define AMP_VAL_LO           0
`define OFS_SEL_HI           15
`define OFS_SEL_LO           14
`define OFS_FIRST_HI         13
`define OFS_FIRST_LO         7
`define OFS_SECOND_HI        6
`define OFS_SECOND_LO        0

// Gain divisor 1024 as a shift
`define GAIN_FRAC_BITS       10
// Offset LSB sits at bit 5 of a 16-bit result (11-bit scale)
`define OFS_SHIFT            5

// Angle engine constants, angle in 1/256 degree
`define ENGINE_ITERS         4'hE
`define ANGLE_HALF_TURN      20'h0_B400
`define ANGLE_FULL_TURN      20'h1_6800
`define ANGLE_OUT_SHIFT      4
`define VEC_GAIN_COMP        16'h9B75

`endif

// ### src/angle_corr_pkg.sv
package angle_corr_pkg;

    typedef enum logic [1:0] {
        ENG_IDLE = 2'b00,
        ENG_RUN  = 2'b01,
        ENG_DONE = 2'b10
    } engine_state_t;

    typedef enum logic [1:0] {
        PAIR_NONE = 2'b00,
        PAIR_XY   = 2'b01,
        PAIR_YZ   = 2'b10,
        PAIR_XZ   = 2'b11
    } axis_pair_t;

endpackage

// ### src/rotation_angle_engine.sv
`timescale 1ns/1ps
`include "angle_corr_regs.svh"

module rotation_angle_engine
    import angle_corr_pkg::*;
(
    // Clock and reset
    input  wire logic               clk_i,
    input  wire logic               nrst_i,
    // Operands
    input  wire logic               start_i,
    input  wire logic signed [15:0] a_i,
    input  wire logic signed [15:0] b_i,
    // Results
    output logic                    busy_o,
    output logic                    done_o,
    output logic [15:0]             angle_o,
    output logic [15:0]             mag_o
);

    engine_state_t      state_reg, state_next;
    logic signed [18:0] x_reg, x_next;
    logic signed [18:0] y_reg, y_next;
    logic signed [19:0] z_reg, z_next;
    logic [3:0]         iter_reg, iter_next;
    logic               done_reg, done_next;
    logic [15:0]        angle_reg, angle_next;
    logic [15:0]        mag_reg, mag_next;

    function automatic logic signed [19:0] atan_step(input logic [3:0] i);
        case (i)
            4'h0:    atan_step = 20'h0_2D00;
            4'h1:    atan_step = 20'h0_1A91;
            4'h2:    atan_step = 20'h0_0E09;
            4'h3:    atan_step = 20'h0_0720;
            4'h4:    atan_step = 20'h0_0394;
            4'h5:    atan_step = 20'h0_01CA;
            4'h6:    atan_step = 20'h0_00E5;
            4'h7:    atan_step = 20'h0_0073;
            4'h8:    atan_step = 20'h0_0039;
            4'h9:    atan_step = 20'h0_001D;
            4'hA:    atan_step = 20'h0_000E;
            4'hB:    atan_step = 20'h0_0007;
            4'hC:    atan_step = 20'h0_0004;
            4'hD:    atan_step = 20'h0_0002;
            default: atan_step = 20'h0_0000;
        endcase
    endfunction

    always_comb begin
        logic signed [18:0] dx;
        logic signed [18:0] dy;
        logic signed [19:0] zw;
        logic [34:0]        prod;
        dx         = y_reg >>> iter_reg;
        dy         = x_reg >>> iter_reg;
        zw         = z_reg;
        prod       = 35'(unsigned'(x_reg[17:0])) * 35'(`VEC_GAIN_COMP);
        state_next = state_reg;
        x_next     = x_reg;
        y_next     = y_reg;
        z_next     = z_reg;
        iter_next  = iter_reg;
        done_next  = 1'b0;
        angle_next = angle_reg;
        mag_next   = mag_reg;
        case (state_reg)
            ENG_IDLE: begin
                if (start_i) begin
                    // Fold left half-plane onto the right
                    if (a_i < 0) begin
                        x_next = -19'(a_i);
                        y_next = -19'(b_i);
                        z_next = `ANGLE_HALF_TURN;
                    end else begin
                        x_next = 19'(a_i);
                        y_next = 19'(b_i);
                        z_next = 20'h0_0000;
                    end
                    iter_next  = 4'h0;
                    state_next = ENG_RUN;
                end
            end
            ENG_RUN: begin
                // Vectoring step drives y toward zero
                if (y_reg >= 0) begin
                    x_next = x_reg + dx;
                    y_next = y_reg - dy;
                    z_next = z_reg + atan_step(iter_reg);
                end else begin
                    x_next = x_reg - dx;
                    y_next = y_reg + dy;
                    z_next = z_reg - atan_step(iter_reg);
                end
                iter_next = iter_reg + 4'h1;
                if (iter_reg == `ENGINE_ITERS - 4'h1) begin
                    state_next = ENG_DONE;
                end
            end
            ENG_DONE: begin
                if (zw < 0) begin
                    zw = zw + `ANGLE_FULL_TURN;
                end
                if (zw >= `ANGLE_FULL_TURN) begin
                    zw = zw - `ANGLE_FULL_TURN;
                end
                angle_next = {3'b000, zw[`ANGLE_OUT_SHIFT +: 13]};
                mag_next   = (prod[34:32] != 3'b000) ? 16'hFFFF : prod[31:16];
                done_next  = 1'b1;
                state_next = ENG_IDLE;
            end
            default: state_next = ENG_IDLE;
        endcase
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_reg <= ENG_IDLE;
            x_reg     <= 19'h0_0000;
            y_reg     <= 19'h0_0000;
            z_reg     <= 20'h0_0000;
            iter_reg  <= 4'h0;
            done_reg  <= 1'b0;
            angle_reg <= `RESULT_RST;
            mag_reg   <= `RESULT_RST;
        end else begin
            state_reg <= state_next;
            x_reg     <= x_next;
            y_reg     <= y_next;
            z_reg     <= z_next;
            iter_reg  <= iter_next;
            done_reg  <= done_next;
            angle_reg <= angle_next;
            mag_reg   <= mag_next;
        end
    end

    assign busy_o  = (state_reg != ENG_IDLE);
    assign done_o  = done_reg;
    assign angle_o = angle_reg;
    assign mag_o   = mag_reg;

endmodule

// ### verif/angle_corr_props.sv
`timescale 1ns/1ps
module angle_corr_props (
    // Watched ports
    input wire logic        clk_i,
    input wire logic        nrst_i,
    input wire logic [5:0]  reg_addr_i,
    input wire logic        reg_rd_i,
    input wire logic [15:0] reg_rdata_o,
    input wire logic        raw_valid_i,
    input wire logic        result_valid_o,
    input wire logic [15:0] angle_o,
    input wire logic [15:0] magnitude_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);

    sequence s_read(a);
        reg_rd_i && reg_addr_i == a;
    endsequence
    sequence s_sampled;
        $past(raw_valid_i, 16) || $past(raw_valid_i, 17) || $past(raw_valid_i, 18);
    endsequence

    a_gain_rsvd_zero: assert property (s_read(6'h11) |=> reg_rdata_o[13:11] == 3'b000)
        else $error("gain setup reserved bits set");
    a_angle_read_match: assert property (s_read(6'h13) |=> reg_rdata_o == $past(angle_o))
        else $error("angle read differs from result");
    a_mag_read_match: assert property (s_read(6'h14) |=>
        reg_rdata_o == $past(magnitude_o))
        else $error("magnitude read differs from result");
    a_angle_in_range: assert property (angle_o <= 16'h167F)
        else $error("angle beyond full turn");
    a_results_hold: assert property (!result_valid_o |->
        $stable(angle_o) && $stable(magnitude_o))
        else $error("result changed without valid");
    a_valid_one_cycle: assert property (result_valid_o |=> !result_valid_o)
        else $error("valid longer than one cycle");
    a_result_latency: assert property (result_valid_o |-> s_sampled)
        else $error("result without sample");
    a_rdata_hold: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
        else $error("read data changed without read");
endmodule

bind angle_gain_offset_correction angle_corr_props u_props (
    .clk_i(clk_i), .nrst_i(nrst_i), .reg_addr_i(reg_addr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .raw_valid_i(raw_valid_i), .result_valid_o(result_valid_o),
    .angle_o(angle_o), .magnitude_o(magnitude_o)
);

// ### verif/reg_host.sv
`timescale 1ns/1ps
module reg_host (
    // Register port side
    input  wire logic        clk_i,
    input  wire logic [15:0] reg_rdata_i,
    output logic [5:0]       reg_addr_o,
    output logic             reg_wr_o,
    output logic [15:0]      reg_wdata_o,
    output logic             reg_rd_o
);
    initial begin
        reg_addr_o = 6'h00;
        reg_wr_o = 1'b0;
        reg_wdata_o = 16'h0000;
        reg_rd_o = 1'b0;
    end

    task automatic wr(input logic [5:0] a, input logic [15:0] d);
        @(negedge clk_i);
        reg_addr_o = a;
        reg_wdata_o = d;
        reg_wr_o = 1'b1;
        @(negedge clk_i);
        reg_wr_o = 1'b0;
        reg_wdata_o = ~d;
    endtask

    task automatic rd(input logic [5:0] a, output logic [15:0] d);
        @(negedge clk_i);
        reg_addr_o = a;
        reg_rd_o = 1'b1;
        @(negedge clk_i);
        reg_rd_o = 1'b0;
        @(negedge clk_i);
        d = reg_rdata_i;
    endtask
endmodule

// ### verif/tb_angle_gain_offset_correction.sv
`timescale 1ns/1ps
module tb_angle_gain_offset_correction;
    logic               clk_i = 1'b0;
    logic               nrst_i = 1'b0;
    logic [5:0]         reg_addr_i;
    logic               reg_wr_i, reg_rd_i, result_valid_o;
    logic [15:0]        reg_wdata_i, reg_rdata_o, angle_o, magnitude_o, rv;
    logic               raw_valid_i = 1'b0;
    logic signed [15:0] x_raw_i = 16'h0000;
    logic signed [15:0] y_raw_i = 16'h0000;
    logic signed [15:0] z_raw_i = 16'h0000;
    logic [1:0]         angle_pair_i = 2'b00;
    logic [1:0]         gsel, osel;
    logic [10:0]        gval;
    logic signed [6:0]  o1, o2;
    int                 errors = 0;
    int                 cmp_count = 0;

    angle_gain_offset_correction dut (
        .clk_i(clk_i), .nrst_i(nrst_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
        .reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
        .raw_valid_i(raw_valid_i), .x_raw_i(x_raw_i), .y_raw_i(y_raw_i), .z_raw_i(z_raw_i),
        .angle_pair_i(angle_pair_i), .result_valid_o(result_valid_o), .angle_o(angle_o),
        .magnitude_o(magnitude_o)
    );
    reg_host host (
        .clk_i(clk_i), .reg_rdata_i(reg_rdata_o), .reg_addr_o(reg_addr_i),
        .reg_wr_o(reg_wr_i), .reg_wdata_o(reg_wdata_i), .reg_rd_o(reg_rd_i)
    );

    always #50 clk_i = ~clk_i;

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp,
                         input int tol);
        logic signed [17:0] d;
        bit                 ok;
        d = $signed({2'b00, seen}) - $signed({2'b00, exp});
        ok = (d <= tol && d >= -tol);
        cmp_count++;
        if (!ok) begin
            errors++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic cfg(input logic [1:0] gs, input logic [10:0] gv, input logic [1:0] os,
                       input logic [6:0] a, input logic [6:0] b);
        gsel = gs;
        gval = gv;
        osel = os;
        o1 = a;
        o2 = b;
        host.wr(6'h11, {gs, 3'b000, gv});
        host.wr(6'h12, {os, a, b});
    endtask

    task automatic sample(input logic [1:0] p, input int x, input int y, input int z);
        int          v[3];
        int          n, a, b;
        real         ang;
        logic [15:0] ea, em;
        v = '{x, y, z};
        if (gsel != 2'b00) v[gsel - 1] = (v[gsel - 1] * int'(gval)) >>> 10;
        if (osel[0]) v[p == 2'b10] += 32 * int'(o1);
        if (osel[1]) v[p == 2'b01 ? 1 : 2] += 32 * int'(o2);
        a = v[p == 2'b10];
        b = v[p == 2'b01 ? 1 : 2];
        ang = $atan2(b, a) * 57.29577951308232;
        if (ang < 0.0) ang += 360.0;
        ea = 16'(int'(ang * 16.0));
        em = 16'(int'($sqrt(real'(a) * a + real'(b) * b)));
        @(negedge clk_i);
        angle_pair_i = p;
        x_raw_i = 16'(x);
        y_raw_i = 16'(y);
        z_raw_i = 16'(z);
        raw_valid_i = 1'b1;
        @(negedge clk_i);
        raw_valid_i = 1'b0;
        x_raw_i = ~x_raw_i;
        y_raw_i = ~y_raw_i;
        z_raw_i = ~z_raw_i;
        n = 1;
        while (result_valid_o !== 1'b1 && n < 40) begin
            @(negedge clk_i);
            n++;
        end
        check("latency", 16'(n), 16'h0012, 1);
        check("angle", angle_o, ea, 2);
        check("magnitude", magnitude_o, em, em / 64 + 2);
        host.rd(6'h13, rv);
        check("angle_reg", rv, ea, 2);
        host.rd(6'h14, rv);
        check("magnitude_reg", rv, em, em / 64 + 2);
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset_vals;
        for (int a = 16; a < 22; a++) begin
            host.rd(6'(a), rv);
            check("reset_read", rv, 16'h0000, 0);
        end
        $display("reset_vals done");
    endtask

    task automatic t_reg_access;
        logic [5:0] ro[3] = '{6'h13, 6'h14, 6'h3F};
        host.wr(6'h11, 16'hFFFF);
        host.rd(6'h11, rv);
        check("gain_setup", rv, 16'hC7FF, 0);
        host.wr(6'h12, 16'hFFFF);
        host.rd(6'h12, rv);
        check("offset_setup", rv, 16'hFFFF, 0);
        foreach (ro[i]) begin
            host.wr(ro[i], 16'hA5A5);
            host.rd(ro[i], rv);
            check("read_only", rv, 16'h0000, 0);
        end
        $display("reg_access done");
    endtask

    task automatic t_gain;
        for (int g = 0; g < 4; g++) begin
            cfg(2'(g), 11'h200, 2'b00, 7'h00, 7'h00);
            sample(2'b11, 1000, 700, 1000);
        end
        cfg(2'b10, 11'h7FF, 2'b00, 7'h00, 7'h00);
        sample(2'b01, 1000, 600, 0);
        $display("gain done");
    endtask

    task automatic t_offset;
        for (int s = 0; s < 4; s++) begin
            cfg(2'b00, 11'h000, 2'(s), 7'h3F, 7'h40);
            for (int p = 1; p < 4; p++) begin
                sample(2'(p), 3000, 3000, 3000);
            end
        end
        $display("offset done");
    endtask

    task automatic t_no_pair;
        int hit;
        hit = 0;
        cfg(2'b00, 11'h000, 2'b11, 7'h3F, 7'h40);
        @(negedge clk_i);
        angle_pair_i = 2'b00;
        raw_valid_i = 1'b1;
        @(negedge clk_i);
        raw_valid_i = 1'b0;
        repeat (25) begin
            @(negedge clk_i);
            if (result_valid_o !== 1'b0) hit++;
        end
        check("no_pair", 16'(hit), 16'h0000, 0);
        $display("no_pair done");
    endtask

    task automatic t_rotation;
        real r;
        cfg(2'b00, 11'h000, 2'b00, 7'h00, 7'h00);
        for (int k = 0; k < 8; k++) begin
            r = (k * 45.0 + 10.0) / 57.29577951308232;
            sample(2'b01, int'(2000.0 * $cos(r)), int'(2000.0 * $sin(r)), 0);
            check("const_mag", magnitude_o, 16'h07D0, 40);
        end
        $display("rotation done");
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic give_verdict;
        $display("Comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    initial begin
        repeat (12) @(negedge clk_i);
        nrst_i = 1'b1;
        t_reset_vals();
        t_reg_access();
        t_gain();
        t_offset();
        t_no_pair();
        t_rotation();
        give_verdict();
    end

    initial begin
        #2000000;
        errors++;
        give_verdict();
    end
endmodule
